// *** hw/ccc_cfg_regs.sv ***
`timescale 1ns/1ps
// Contract
// [R1] text cursor height is a 5-bit zero-based count, zero meaning one pixel.
// [R2] text cursor dimensions are scaled by the character enlargement factor.
// [R3] graphic cursor x is 13 bits from a low byte and a 5-bit high part.
// [R4] graphic cursor y is 13 bits from a low byte and a 5-bit high part.
// [R5] two independent 8-bit cursor colours, laid out RRRGGGBB.
// [R6] page select bit 0 picks the register page, and software keeps bit 1 at zero.
// [R7] canvas start address is 32 bits over four bytes, with the low two bits fixed at zero.
// [R8] canvas image width is 13 bits in 4-pixel steps, with the low two bits fixed at zero.
// [R9] in linear addressing mode canvas base, width and window coordinates are disregarded.
// [R10] software keeps the window left x plus window width within 8188 pixels.
// [R11] with both cursors enabled the graphic cursor shows and the text cursor is suppressed.
module ccc_cfg_regs
	import ccc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] char_scale,
	input wire logic linear_mode,
	input wire logic text_cursor_en,
	input wire logic gfx_cursor_en,
	output logic [7:0] text_cursor_rows,
	output logic text_cursor_show,
	output logic gfx_cursor_show,
	output logic [12:0] gfx_cursor_x,
	output logic [12:0] gfx_cursor_y,
	output logic [7:0] gfx_cursor_colour_a,
	output logic [7:0] gfx_cursor_colour_b,
	output logic [2:0] colour_a_red,
	output logic [2:0] colour_a_green,
	output logic [1:0] colour_a_blue,
	output logic page_sel,
	output logic [31:0] canvas_base,
	output logic [12:0] canvas_width,
	output logic [7:0] active_win_left_low
);
	// ==========================================
	// address decode
	function automatic logic [4:0] ccc_slot(input logic [7:0] idx);
		case (idx)
			CCC_IDX_CUR_HEIGHT: ccc_slot = 5'h00;
			CCC_IDX_GCX_LO: ccc_slot = 5'h01;
			CCC_IDX_GCX_HI: ccc_slot = 5'h02;
			CCC_IDX_GCY_LO: ccc_slot = 5'h03;
			CCC_IDX_GCY_HI: ccc_slot = 5'h04;
			CCC_IDX_GCC_A: ccc_slot = 5'h05;
			CCC_IDX_GCC_B: ccc_slot = 5'h06;
			CCC_IDX_PAGE: ccc_slot = 5'h07;
			CCC_IDX_CVS_B0: ccc_slot = 5'h08;
			CCC_IDX_CVS_B1: ccc_slot = 5'h09;
			CCC_IDX_CVS_B2: ccc_slot = 5'h0A;
			CCC_IDX_CVS_B3: ccc_slot = 5'h0B;
			CCC_IDX_CW_LO: ccc_slot = 5'h0C;
			CCC_IDX_CW_HI: ccc_slot = 5'h0D;
			CCC_IDX_AWX_LO: ccc_slot = 5'h0E;
			default: ccc_slot = 5'h10;
		endcase
	endfunction

	ccc_wr_if wr ();

	wire logic [4:0] slot = ccc_slot(paddr[9:2]);
	wire logic mapped = (slot[4] == 1'b0) && (paddr[31:10] == 22'h0) && (paddr[1:0] == 2'b00);
	wire logic access = psel && penable;
	// zero-wait slave, byte lane 0 carries the register
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	assign wr.we = access && pwrite && mapped && pstrb[0];
	assign wr.sel = slot[3:0];
	assign wr.wdata = pwdata[7:0];

	ccc_reg_bank u_bank (
		.pclk(pclk),
		.presetn(presetn),
		.wr(wr)
	);

	// read data registered at the setup phase
	logic [31:0] prdata_q;
	wire logic [31:0] prdata_d = mapped ? {24'h000000, wr.rdata[slot[3:0]]} : CCC_BAD_ADDR_DATA;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_q <= prdata_d;
		end
	end
	assign prdata = prdata_q;

	// ==========================================
	// field outputs
	// [R1] zero-based height
	wire logic [5:0] cur_rows_base = {1'b0, wr.rdata[0][4:0]} + 6'h01;
	// [R2] scale by enlargement
	wire logic [2:0] scale_n = {1'b0, char_scale} + 3'h1;
	wire logic [8:0] cur_rows_scaled = {3'b000, cur_rows_base} * {6'h00, scale_n};
	assign text_cursor_rows = cur_rows_scaled[7:0];
	// [R11] graphic cursor wins
	assign gfx_cursor_show = gfx_cursor_en;
	assign text_cursor_show = text_cursor_en && !gfx_cursor_en;
	// [R3] horizontal location
	assign gfx_cursor_x = {wr.rdata[2][4:0], wr.rdata[1]};
	// [R4] vertical location
	assign gfx_cursor_y = {wr.rdata[4][4:0], wr.rdata[3]};
	// [R5] colours and field split
	assign gfx_cursor_colour_a = wr.rdata[5];
	assign gfx_cursor_colour_b = wr.rdata[6];
	assign colour_a_red = wr.rdata[5][CCC_RED_LSB +: 3];
	assign colour_a_green = wr.rdata[5][CCC_GREEN_LSB +: 3];
	assign colour_a_blue = wr.rdata[5][CCC_BLUE_LSB +: 2];
	// [R6] page select bit
	assign page_sel = wr.rdata[7][CCC_PAGE_SEL_BIT];
	// [R9] linear mode blanks canvas settings
	// [R7] word aligned base
	assign canvas_base = linear_mode ? 32'h0000_0000 :
		{wr.rdata[11], wr.rdata[10], wr.rdata[9], wr.rdata[8][7:2], 2'b00};
	// [R8] 4-pixel width
	assign canvas_width = linear_mode ? 13'h0000 : {wr.rdata[13][4:0], wr.rdata[12][7:2], 2'b00};
	assign active_win_left_low = linear_mode ? 8'h00 : wr.rdata[14];

	// ==========================================
	// checks
	// write strobe on lane 0, without the address map check the bank also applies
	wire logic wr_cyc = access && pwrite && pstrb[0];
	// [R1] height one more than field
	a_cur_height: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		char_scale == 2'b00 |-> text_cursor_rows == 8'({3'b000, wr.rdata[0][4:0]} + 8'h01))
		else $error("cursor height not zero based");
	// [R2] scaled by factor
	a_cur_scale: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		char_scale == 2'b01 |-> text_cursor_rows == 8'({2'b00, wr.rdata[0][4:0], 1'b0} + 8'h02))
		else $error("cursor height not scaled");
	// [R3] x write lands next cycle
	a_gcx_write: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(access && pwrite && pstrb[0] && paddr == {22'h0, CCC_IDX_GCX_HI, 2'b00})
		|=> gfx_cursor_x[12:8] == $past(pwdata[4:0]))
		else $error("cursor x high not stored");
	// [R4] y write lands next cycle
	a_gcy_write: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
		(access && pwrite && pstrb[0] && paddr == {22'h0, CCC_IDX_GCY_LO, 2'b00})
		|=> gfx_cursor_y[7:0] == $past(pwdata[7:0]))
		else $error("cursor y low not stored");
	// [R5] colour b write
	a_colour_b: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(access && pwrite && pstrb[0] && paddr == {22'h0, CCC_IDX_GCC_B, 2'b00})
		|=> gfx_cursor_colour_b == $past(pwdata[7:0]))
		else $error("colour b not stored");
	// [R6] page bit follows write
	a_page_sel: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(access && pwrite && pstrb[0] && paddr == {22'h0, CCC_IDX_PAGE, 2'b00})
		|=> page_sel == $past(pwdata[0]))
		else $error("page select not stored");
	// [R7] base low bits zero
	a_base_align: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		canvas_base[1:0] == 2'b00 && wr.rdata[8][1:0] == 2'b00)
		else $error("canvas base not aligned");
	// [R8] width low bits zero
	a_width_align: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		canvas_width[1:0] == 2'b00 && wr.rdata[13][7:5] == 3'b000)
		else $error("canvas width bad bits");
	// [R9] linear mode ignores settings
	a_linear_mode: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		linear_mode |-> canvas_base == 32'h0 && canvas_width == 13'h0 && active_win_left_low == 8'h0)
		else $error("linear mode not honoured");
	// [R11] cursor priority
	a_cur_priority: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		gfx_cursor_en |-> !text_cursor_show && gfx_cursor_show)
		else $error("text cursor not suppressed");

	// [R2] triple size cursor
	a_cur_triple: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		char_scale == 2'b10 |-> text_cursor_rows == 8'({3'b000, wr.rdata[0][4:0]} * 8'h03 + 8'h03))
		else $error("cursor height not tripled");

	// [R2] largest enlargement
	a_cur_quad: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		char_scale == 2'b11 |-> text_cursor_rows == 8'({1'b0, wr.rdata[0][4:0], 2'b00} + 8'h04))
		else $error("cursor height not quadrupled");

	// [R1] height write masked
	a_height_write: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		(wr_cyc && paddr == {22'h0, CCC_IDX_CUR_HEIGHT, 2'b00})
		|=> wr.rdata[0] == ($past(pwdata[7:0]) & CCC_MASK_5BIT))
		else $error("cursor height not stored");

	// [R1] height spare bits zero
	a_height_spare: assert property (@(posedge pclk) disable iff (!presetn) // [R1]
		wr.rdata[0][7:5] == 3'b000)
		else $error("cursor height spare bits set");

	// [R3] x low byte write
	a_gcx_low: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		(wr_cyc && paddr == {22'h0, CCC_IDX_GCX_LO, 2'b00})
		|=> gfx_cursor_x[7:0] == $past(pwdata[7:0]))
		else $error("cursor x low not stored");

	// [R4] y high part write
	a_gcy_high: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
		(wr_cyc && paddr == {22'h0, CCC_IDX_GCY_HI, 2'b00})
		|=> gfx_cursor_y[12:8] == $past(pwdata[4:0]))
		else $error("cursor y high not stored");

	// [R3] high parts spare bits zero
	a_pos_spare: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		wr.rdata[2][7:5] == 3'b000 && wr.rdata[4][7:5] == 3'b000)
		else $error("cursor position spare bits set");

	// [R5] colour a write
	a_colour_a: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		(wr_cyc && paddr == {22'h0, CCC_IDX_GCC_A, 2'b00})
		|=> gfx_cursor_colour_a == $past(pwdata[7:0]))
		else $error("colour a not stored");

	// [R5] colour split order
	a_colour_split: assert property (@(posedge pclk) disable iff (!presetn) // [R5]
		{colour_a_red, colour_a_green, colour_a_blue} == gfx_cursor_colour_a)
		else $error("colour fields misplaced");

	// [R6] whole page byte kept
	a_page_byte: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		(wr_cyc && paddr == {22'h0, CCC_IDX_PAGE, 2'b00})
		|=> wr.rdata[7] == $past(pwdata[7:0]))
		else $error("page byte not stored");

	// [R7] base low byte aligned
	a_base_low: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(wr_cyc && paddr == {22'h0, CCC_IDX_CVS_B0, 2'b00})
		|=> linear_mode || canvas_base[7:0] == ($past(pwdata[7:0]) & CCC_MASK_ALIGN))
		else $error("canvas base low not stored");

	// [R7] base top byte
	a_base_top: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		(wr_cyc && paddr == {22'h0, CCC_IDX_CVS_B3, 2'b00})
		|=> linear_mode || canvas_base[31:24] == $past(pwdata[7:0]))
		else $error("canvas base top not stored");

	// [R8] width low byte
	a_width_low: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(wr_cyc && paddr == {22'h0, CCC_IDX_CW_LO, 2'b00})
		|=> linear_mode || canvas_width[7:0] == ($past(pwdata[7:0]) & CCC_MASK_ALIGN))
		else $error("canvas width low not stored");

	// [R8] width high part
	a_width_high: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		(wr_cyc && paddr == {22'h0, CCC_IDX_CW_HI, 2'b00})
		|=> linear_mode || canvas_width[12:8] == $past(pwdata[4:0]))
		else $error("canvas width high not stored");

	// [R9] window left outside linear mode
	a_win_left: assert property (@(posedge pclk) disable iff (!presetn) // [R9]
		(wr_cyc && paddr == {22'h0, CCC_IDX_AWX_LO, 2'b00})
		|=> linear_mode || active_win_left_low == $past(pwdata[7:0]))
		else $error("window left not stored");

	// [R11] text cursor alone shows
	a_text_only: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		text_cursor_en && !gfx_cursor_en |-> text_cursor_show)
		else $error("text cursor not shown");

	// [R11] graphic cursor off
	a_gfx_off: assert property (@(posedge pclk) disable iff (!presetn) // [R11]
		!gfx_cursor_en |-> !gfx_cursor_show)
		else $error("graphic cursor shown while off");

	// zero wait bus
	a_zero_wait: assert property (@(posedge pclk) disable iff (!presetn)
		pready == 1'b1)
		else $error("bus not zero wait");

	// error on unmapped access
	a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		access && !mapped |-> pslverr)
		else $error("unmapped access not flagged");

	// no error on mapped access
	a_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		access && mapped |-> !pslverr)
		else $error("mapped access flagged");

	// no error outside access
	a_err_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!access |-> !pslverr)
		else $error("error outside access");

	// unmapped read returns zero
	a_read_bad: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable && !pwrite && !mapped) |=> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");

	// upper read bits zero
	a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
		prdata[31:8] == 24'h000000)
		else $error("read upper bits set");

	// read data stands between reads
	a_read_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("read data changed");

	// lane zero off drops the write
	a_strb_drop: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && !pstrb[0])
		|=> $stable(gfx_cursor_x) && $stable(gfx_cursor_y) && $stable(page_sel))
		else $error("write without lane zero landed");

	// unmapped write dropped
	a_bad_write: assert property (@(posedge pclk) disable iff (!presetn)
		(access && pwrite && !mapped)
		|=> $stable(gfx_cursor_x) && $stable(gfx_cursor_colour_b) && $stable(page_sel))
		else $error("unmapped write landed");
endmodule // ccc_cfg_regs

// *** pkg/ccc_pkg.sv ***
package ccc_pkg;
	// ==========================================
	// register indices (byte-wide, index*4 = byte address)
	localparam logic [7:0] CCC_IDX_CUR_HEIGHT = 8'h3F;
	localparam logic [7:0] CCC_IDX_GCX_LO = 8'h40;
	localparam logic [7:0] CCC_IDX_GCX_HI = 8'h41;
	localparam logic [7:0] CCC_IDX_GCY_LO = 8'h42;
	localparam logic [7:0] CCC_IDX_GCY_HI = 8'h43;
	localparam logic [7:0] CCC_IDX_GCC_A = 8'h44;
	localparam logic [7:0] CCC_IDX_GCC_B = 8'h45;
	localparam logic [7:0] CCC_IDX_PAGE = 8'h46;
	localparam logic [7:0] CCC_IDX_CVS_B0 = 8'h50;
	localparam logic [7:0] CCC_IDX_CVS_B1 = 8'h51;
	localparam logic [7:0] CCC_IDX_CVS_B2 = 8'h52;
	localparam logic [7:0] CCC_IDX_CVS_B3 = 8'h53;
	localparam logic [7:0] CCC_IDX_CW_LO = 8'h54;
	localparam logic [7:0] CCC_IDX_CW_HI = 8'h55;
	localparam logic [7:0] CCC_IDX_AWX_LO = 8'h56;
	// ==========================================
	// writable-bit masks per register
	localparam logic [7:0] CCC_MASK_5BIT = 8'h1F;
	localparam logic [7:0] CCC_MASK_FULL = 8'hFF;
	localparam logic [7:0] CCC_MASK_ALIGN = 8'hFC;
	localparam logic [7:0] CCC_RESET_VAL = 8'h00;
	localparam int CCC_NREG = 15;
	localparam int CCC_PAGE_SEL_BIT = 0;
	localparam int CCC_PAGE_MBZ_BIT = 1;
	localparam logic [31:0] CCC_BAD_ADDR_DATA = 32'h0000_0000;
	// ==========================================
	// colour field positions, RRRGGGBB
	localparam int CCC_RED_LSB = 5;
	localparam int CCC_GREEN_LSB = 2;
	localparam int CCC_BLUE_LSB = 0;
endpackage

// *** pkg/ccc_wr_if.sv ***
`timescale 1ns/1ps
// write/read port between bus decoder and register bank
interface ccc_wr_if;
	logic we;
	logic [3:0] sel;
	logic [7:0] wdata;
	logic [7:0] rdata [15];
	modport bus (output we, output sel, output wdata, input rdata);
	modport bank (input we, input sel, input wdata, output rdata);
endinterface // ccc_wr_if

// *** hw/ccc_reg_bank.sv ***
`timescale 1ns/1ps
module ccc_reg_bank
	import ccc_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	ccc_wr_if.bank wr
);
	// ==========================================
	// masks: reserved and fixed bits hold zero
	function automatic logic [7:0] ccc_mask(input int i);
		case (i)
			0, 2, 4, 13: ccc_mask = CCC_MASK_5BIT;
			8, 12: ccc_mask = CCC_MASK_ALIGN;
			default: ccc_mask = CCC_MASK_FULL;
		endcase
	endfunction

	// ==========================================
	// one byte register per slot
	genvar g;
	generate
		for (g = 0; g < CCC_NREG; g++) begin : g_reg
			logic [7:0] r_q;
			wire hit = wr.we && (wr.sel == 4'(g));
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					r_q <= CCC_RESET_VAL;
				end else if (hit) begin
					r_q <= wr.wdata & ccc_mask(g);
				end
			end
			assign wr.rdata[g] = r_q;
		end
	endgenerate
endmodule // ccc_reg_bank

// *** tb/ccc_host.sv ***
`timescale 1ns/1ps
// ==========
// host processor model, apb master side
module ccc_host (
	input wire logic pclk,
	input wire logic pready,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [31:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb
);
	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// one transfer, held until pready is seen high or 20 cycles have passed
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s, output bit ok);
		ok = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 20 && !ok; i++) begin
			@(posedge pclk);
			ok = pready;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // ccc_host

// *** tb/ccc_cfg_regs_tb.sv ***
`timescale 1ns/1ps
// ==========
// register bank bench
module ccc_cfg_regs_tb import ccc_pkg::*;;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, tshow, gshow, page_sel, ok;
	logic [31:0] paddr, pwdata, prdata, cbase;
	logic [3:0] pstrb;
	logic [1:0] char_scale = 2'h0;
	logic linear_mode = 1'b0, text_en = 1'b0, gfx_en = 1'b0;
	logic [7:0] rows;
	logic [12:0] gx, gy, cw;
	logic [7:0] ca, cb, awl;
	logic [2:0] red, green;
	logic [1:0] blue;
	logic [32:0] e_w;
	logic [32:0] exp_q[$];
	logic [7:0] idx[15], msk[15], val[15];
	int bad_count = 0, cmp_count = 0, seed = 32'h27fa;
	always #2.5 pclk = ~pclk;
	ccc_host host (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
	ccc_cfg_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .char_scale(char_scale), .linear_mode(linear_mode),
		.text_cursor_en(text_en), .gfx_cursor_en(gfx_en), .text_cursor_rows(rows),
		.text_cursor_show(tshow), .gfx_cursor_show(gshow), .gfx_cursor_x(gx), .gfx_cursor_y(gy),
		.gfx_cursor_colour_a(ca), .gfx_cursor_colour_b(cb), .colour_a_red(red),
		.colour_a_green(green), .colour_a_blue(blue), .page_sel(page_sel),
		.canvas_base(cbase), .canvas_width(cw), .active_win_left_low(awl));
	// compare, count, report
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: got %h want %h", $time, seen, want);
		end
	endtask
	task automatic tally_and_finish();
		$display("bad_count %0d cmp_count %0d", bad_count, cmp_count);
		if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// note the expected answer, then run the transfer
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [32:0] e);
		exp_q.push_back(e);
		host.xfer(w, a, d, s, ok);
		if (!ok) begin
			bad_count++;
			tally_and_finish();
		end
	endtask
	task automatic settle();
		@(negedge pclk);
	endtask
	// watcher: oldest note against each finished transfer
	always @(posedge pclk) if (psel && penable && pready) begin
		e_w = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1FFFFFFFF;
		chk(pslverr, e_w[32]);
		if (!pwrite) chk(prdata, e_w[31:0]);
	end
	// main sequence
	initial begin
		idx = '{CCC_IDX_CUR_HEIGHT, CCC_IDX_GCX_LO, CCC_IDX_GCX_HI, CCC_IDX_GCY_LO, CCC_IDX_GCY_HI,
			CCC_IDX_GCC_A, CCC_IDX_GCC_B, CCC_IDX_PAGE, CCC_IDX_CVS_B0, CCC_IDX_CVS_B1,
			CCC_IDX_CVS_B2, CCC_IDX_CVS_B3, CCC_IDX_CW_LO, CCC_IDX_CW_HI, CCC_IDX_AWX_LO};
		msk = '{8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFC, 8'hFF, 8'hFF,
			8'hFF, 8'hFC, 8'h1F, 8'hFF};
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		settle();
		chk(rows, 1);
		for (int i = 0; i < 15; i++) bus(1'b0, {idx[i], 2'b00}, 32'h0, 4'hF, 33'h0);
		for (int i = 0; i < 15; i++) begin
			val[i] = $random(seed);
			if (i == 7) val[i][1] = 1'b0;
			if (i == 14) val[i] = 8'h10;
			if (i == 0) val[i][4] = 1'b0;
			val[i] = val[i] & msk[i];
			bus(1'b1, {idx[i], 2'b00}, {24'h0, val[i] | ~msk[i]}, 4'h1, 33'h0);
		end
		for (int i = 0; i < 15; i++) bus(1'b0, {idx[i], 2'b00}, 32'h0, 4'hF, {25'h0, val[i]});
		for (int lm = 0; lm < 2; lm++) begin
			@(posedge pclk);
			linear_mode <= lm[0];
			settle();
			chk(gx, {val[2][4:0], val[1]});
			chk(gy, {val[4][4:0], val[3]});
			chk({ca, cb}, {val[5], val[6]});
			chk({red, green, blue}, val[5]);
			chk(page_sel, val[7][0]);
			chk(cbase, lm ? 0 : {val[11], val[10], val[9], val[8] & 8'hFC});
			chk(cw, lm ? 0 : {val[13][4:0], val[12] & 8'hFC});
			chk(awl, lm ? 0 : val[14]);
		end
		for (int k = 0; k < 16; k++) begin
			@(posedge pclk);
			{gfx_en, text_en, char_scale} <= k[3:0];
			settle();
			chk(rows, (val[0][4:0] + 1) * (k % 4 + 1));
			chk({tshow, gshow}, {k[2] & !k[3], k[3]});
		end
		bus(1'b1, {idx[1], 2'b00}, {24'h0, ~val[1]}, 4'hE, 33'h0);
		bus(1'b1, 32'h11C, 32'hFF, 4'h1, {1'b1, 32'h0});
		bus(1'b0, {idx[1], 2'b00}, 32'h0, 4'hF, {25'h0, val[1]});
		bus(1'b0, 32'h11C, 32'h0, 4'hF, {1'b1, 32'h0});
		bus(1'b0, 32'h101, 32'h0, 4'hF, {1'b1, 32'h0});
		settle();
		tally_and_finish();
	end
endmodule // ccc_cfg_regs_tb
